/* rtl/status_event_flag_manager.sv */
/*
 * Status and event flag manager with command-string delay step.
 * Assumes a command parser on the same clock sends one-cycle command pulses,
 * and that analog-side conditions arrive from pins and need synchronising.
 */
module status_event_flag_manager #(
	parameter int unsigned TICK_LEN = status_flags_pkg::TICK_CYCLES,
	parameter int unsigned OTP_DELAY_MS = status_flags_pkg::OTP_OFF_MS
) (
	input wire logic clk,
	input wire logic srst,
	input wire status_flags_pkg::cmd_t cmd,
	input wire status_flags_pkg::values_t vals,
	input wire status_flags_pkg::cond_t cond_pin,
	input wire status_flags_pkg::pon_mode_t pon_mode,
	input wire logic out_buf_nonempty,
	input wire logic event_read,
	input wire logic [status_flags_pkg::EV_N-1:0] event_enable,
	output logic [status_flags_pkg::EV_N-1:0] event_flags,
	output logic [status_flags_pkg::EV_N-1:0] cond_flags,
	output logic group_summary,
	output logic message_available_flag,
	output logic sequence_running_flag,
	output logic std_exec_err,
	output logic output_enable,
	output logic parser_hold,
	output logic [7:0] error_code,
	output logic [15:0] voltage_setpoint,
	output logic [15:0] voltage_limit,
	output logic [15:0] current_setpoint,
	output logic [15:0] current_limit,
	output logic seq_abort
);
	import status_flags_pkg::*;

	localparam int unsigned TW = $clog2(TICK_LEN + 1);
	localparam int unsigned OW = $clog2(OTP_DELAY_MS + 1);

	// Two-flop synchronisers for the pin conditions
	cond_t cond_s1_r;
	cond_t cond_r;
	cond_t cond_d_r;
	always_ff @(posedge clk) begin
		cond_s1_r <= cond_pin;
		cond_r <= cond_s1_r;
		cond_d_r <= cond_r;
	end

	// Set-point and limit checks; rejected writes leave the register alone
	// voltage over limit
	wire v_set_bad = cmd.volt_set_wr && (vals.volt_new > voltage_limit);
	wire v_lim_bad = cmd.volt_lim_wr && (vals.volt_new < voltage_setpoint);
	wire i_set_bad = cmd.cur_set_wr && (vals.cur_new > current_limit);
	wire i_lim_bad = cmd.cur_lim_wr && (vals.cur_new < current_setpoint);
	wire limit_bad = v_set_bad || v_lim_bad || i_set_bad || i_lim_bad;

	wire macro_bad = cmd.macro_define && ((cmd.macro_len > 8'(MACRO_MAX_CHARS)) ||
		cmd.macro_has_trig);
	wire cmd_bad = cmd.cmd_unknown || cmd.cmd_syntax || cmd.cmd_range;
	wire run_bad = cmd.param_fault || cmd.state_conflict;

	wire seq_lim_bad = cmd.seq_go && ((vals.seq_volt > voltage_limit) ||
		(vals.seq_cur > current_limit));
	wire seq_empty = cmd.seq_go && !vals.seq_has_entries;
	wire seq_bad = seq_lim_bad || seq_empty;

	wire on_blocked = cmd.output_on_cmd && cond_r.trig_off;
	wire on_hot = cmd.output_on_cmd && cond_r.over_temp;
	wire on_ok = cmd.output_on_cmd && !cond_r.trig_off && !cond_r.over_temp;

	// Delay state; parser hold while delaying, when new delay and opc commands are ignored
	dly_state_t dly_state_r;
	dly_state_t dly_state_nxt;
	logic [13:0] dly_ms_r;
	logic [13:0] dly_ms_nxt;
	logic [TW-1:0] tick_r;
	wire tick = (tick_r == TW'(TICK_LEN - 1));
	wire [TW-1:0] tick_nxt = tick ? '0 : tick_r + TW'(1);
	wire dly_start = cmd.delay_cmd && (dly_state_r == DLY_IDLE) &&
		(cmd.delay_ms >= 14'(DELAY_MIN_MS)) && (cmd.delay_ms <= 14'(DELAY_MAX_MS));

	always_comb begin
		dly_state_nxt = dly_state_r;
		dly_ms_nxt = dly_ms_r;
		case (dly_state_r)
			DLY_IDLE: begin
				if (dly_start) begin
					dly_ms_nxt = cmd.delay_ms;
					dly_state_nxt = (cmd.delay_ms == 14'(DELAY_MIN_MS)) ? DLY_LAST : DLY_RUN;
				end
			end
			DLY_RUN: begin
				if (tick) begin
					dly_ms_nxt = dly_ms_r - 14'(1);
					if (dly_ms_r == 14'(2)) begin
						dly_state_nxt = DLY_LAST;
					end
				end
			end
			DLY_LAST: begin
				if (tick) begin
					dly_ms_nxt = '0;
					dly_state_nxt = DLY_IDLE;
				end
			end
			default: begin
				dly_state_nxt = DLY_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			dly_state_r <= DLY_IDLE;
			dly_ms_r <= '0;
			tick_r <= '0;
		end else begin
			dly_state_r <= dly_state_nxt;
			dly_ms_r <= dly_ms_nxt;
			tick_r <= dly_start ? '0 : tick_nxt;
		end
	end

	wire hold_nxt = (dly_state_nxt != DLY_IDLE);

	// Overtemperature shut-off timer counts ms while the condition lasts
	logic [OW-1:0] ot_ms_r;
	wire ot_expire = cond_r.over_temp && (ot_ms_r == OW'(OTP_DELAY_MS)) && output_enable;
	wire ot_clear = cond_d_r.over_temp && !cond_r.over_temp;
	wire ot_restore = ot_clear && (pon_mode == PON_RECALL);
	wire trip = (cond_r.oc_trip && !cond_d_r.oc_trip) || (cond_r.ov_trip && !cond_d_r.ov_trip);

	always_ff @(posedge clk) begin
		if (srst) begin
			ot_ms_r <= '0;
		end else if (!cond_r.over_temp) begin
			ot_ms_r <= '0;
		end else if (tick && (ot_ms_r != OW'(OTP_DELAY_MS))) begin
			ot_ms_r <= ot_ms_r + OW'(1);
		end
	end

	// Output switch: off wins over on; protection holds off until output-on, or until overtemperature clears in PON_RECALL.
	// a trigger input demanding off also forces the output off
	wire out_nxt = (trip || ot_expire || cmd.output_off_cmd || cond_r.trig_off) ? 1'b0 :
		(on_ok || ot_restore) ? 1'b1 : output_enable;

	// Live condition vector; follows state only
	logic [EV_N-1:0] cond_v;
	always_comb begin
		cond_v = '0;
		cond_v[EV_CUR_REG] = cond_r.cur_reg;
		cond_v[EV_VOLT_REG] = cond_r.volt_reg;
		cond_v[EV_PWR_LIM] = cond_r.pwr_lim;
		cond_v[EV_OC_TRIP] = cond_r.oc_trip;
		cond_v[EV_OV_TRIP] = cond_r.ov_trip;
		cond_v[EV_OT_ALARM] = cond_r.over_temp;
		cond_v[EV_SEQ_ERR] = 1'b0;
		cond_v[EV_TRIG] = cond_r.trig_pulse;
	end

	// Event sources; rising edges of conditions (falling for OT clear and sequence done), pulses for errors
	logic [EV_N-1:0] ev_set;
	always_comb begin
		ev_set = cond_v & ~cond_flags;
		ev_set[EV_CUR_REG] = cond_r.cur_reg && !cond_d_r.cur_reg;
		ev_set[EV_VOLT_REG] = cond_r.volt_reg && !cond_d_r.volt_reg;
		ev_set[EV_CMD_ERR] = cmd_bad;
		ev_set[EV_MACRO_ERR] = macro_bad;
		ev_set[EV_RUN_FAULT] = run_bad;
		ev_set[EV_LIMIT_ERR] = limit_bad;
		ev_set[EV_OP_DONE] = cmd.opc_cmd && !parser_hold;
		ev_set[EV_OT_ALARM] = (cond_r.over_temp && !cond_d_r.over_temp) || on_hot;
		ev_set[EV_OT_CLEAR] = ot_clear;
		ev_set[EV_OUT_BLOCK] = on_blocked;
		ev_set[EV_PWR_CYCLE] = 1'b0;
		ev_set[EV_QUERY_ERR] = cmd.talk_addr && !out_buf_nonempty;
		ev_set[EV_SEQ_DONE] = !cond_r.seq_active && cond_d_r.seq_active;
		ev_set[EV_SEQ_ERR] = seq_bad;
		ev_set[EV_TRIG] = cond_r.trig_pulse && !cond_d_r.trig_pulse;
	end

	// set wins over read or clear-status
	wire ev_clr = event_read || cmd.clear_status;
	wire [EV_N-1:0] ev_nxt = (ev_clr ? '0 : event_flags) | ev_set;
	wire std_nxt = (ev_clr ? 1'b0 : std_exec_err) | limit_bad;

	// Error code shown for a blocked output-on or a refused sequence start
	wire [7:0] code_nxt = on_blocked ? ERR_OUT_BLOCKED : seq_lim_bad ? ERR_SEQ_LIMIT :
		seq_empty ? ERR_SEQ_EMPTY : error_code;

	// accepted writes update setpoints and limits
	always_ff @(posedge clk) begin
		if (srst) begin
			voltage_setpoint <= '0;
			voltage_limit <= '1;
			current_setpoint <= '0;
			current_limit <= '1;
		end else begin
			if (cmd.volt_set_wr && !v_set_bad) voltage_setpoint <= vals.volt_new;
			if (cmd.volt_lim_wr && !v_lim_bad) voltage_limit <= vals.volt_new;
			if (cmd.cur_set_wr && !i_set_bad) current_setpoint <= vals.cur_new;
			if (cmd.cur_lim_wr && !i_lim_bad) current_limit <= vals.cur_new;
		end
	end

	// reset clears events but raises power-cycle; power-cycle flag
	always_ff @(posedge clk) begin
		if (srst) begin
			event_flags <= EV_RESET;
			std_exec_err <= 1'b0;
			cond_flags <= '0;
			group_summary <= 1'b0;
			message_available_flag <= 1'b0;
			sequence_running_flag <= 1'b0;
			output_enable <= 1'b0;
			parser_hold <= 1'b0;
			error_code <= ERR_NONE;
			seq_abort <= 1'b0;
		end else begin
			event_flags <= ev_nxt;
			std_exec_err <= std_nxt;
			cond_flags <= cond_v;
			group_summary <= |(ev_nxt & event_enable);
			message_available_flag <= out_buf_nonempty;
			sequence_running_flag <= cond_r.seq_active;
			output_enable <= out_nxt;
			parser_hold <= hold_nxt;
			error_code <= code_nxt;
			seq_abort <= seq_bad;
		end
	end

	// length check helper: cycles held against programmed ms times tick length
	logic [31:0] hold_cnt_r;
	logic [31:0] hold_exp_r;
	always_ff @(posedge clk) begin
		if (srst) begin
			hold_cnt_r <= '0;
			hold_exp_r <= '0;
		end else if (dly_start) begin
			hold_cnt_r <= '0;
			hold_exp_r <= 32'(cmd.delay_ms) * 32'(TICK_LEN);
		end else if (parser_hold) begin
			hold_cnt_r <= hold_cnt_r + 32'h1;
		end
	end

	// Checks next to the logic
	sequence s_hold_end;
		$fell(parser_hold);
	endsequence
	sequence s_bad_vset;
		cmd.volt_set_wr && (vals.volt_new > voltage_limit);
	endsequence
	a_vset_reject: assert property (@(posedge clk) disable iff (srst)
		s_bad_vset |=> event_flags[EV_LIMIT_ERR] && std_exec_err &&
		$stable(voltage_setpoint)) else $error("rejected setpoint not flagged");
	a_delay_hold: assert property (@(posedge clk) disable iff (srst)
		dly_start |=> parser_hold) else $error("delay released early");
	a_delay_len: assert property (@(posedge clk) disable iff (srst)
		s_hold_end |-> hold_cnt_r == hold_exp_r) else $error("delay length wrong");
	a_hold_state: assert property (@(posedge clk) disable iff (srst)
		parser_hold == (dly_state_r != DLY_IDLE)) else $error("parser not held");
	a_macro_err: assert property (@(posedge clk) disable iff (srst)
		macro_bad |=> event_flags[EV_MACRO_ERR]) else $error("macro error lost");
	a_cur_reject: assert property (@(posedge clk) disable iff (srst)
		cmd.cur_set_wr && (vals.cur_new > current_limit) |=> event_flags[EV_LIMIT_ERR] &&
		$stable(current_setpoint)) else $error("rejected current setpoint not flagged");
	a_ot_refuse: assert property (@(posedge clk) disable iff (srst)
		on_hot |=> event_flags[EV_OT_ALARM] && !$rose(output_enable))
		else $error("output-on accepted while overheated");
	a_ov_trip: assert property (@(posedge clk) disable iff (srst)
		cond_r.ov_trip && !cond_d_r.ov_trip |=> !output_enable && event_flags[EV_OV_TRIP])
		else $error("overvoltage trip not handled");
	a_pwr_lim: assert property (@(posedge clk) disable iff (srst)
		cond_r.pwr_lim && !cond_d_r.pwr_lim |=> event_flags[EV_PWR_LIM])
		else $error("power limit event lost");
	a_cmd_err: assert property (@(posedge clk) disable iff (srst)
		cmd_bad |=> event_flags[EV_CMD_ERR]) else $error("command error lost");
	a_out_block: assert property (@(posedge clk) disable iff (srst)
		on_blocked |=> !output_enable && error_code == ERR_OUT_BLOCKED &&
		event_flags[EV_OUT_BLOCK]) else $error("blocked output-on accepted");
	a_trip_off: assert property (@(posedge clk) disable iff (srst)
		trip |=> !output_enable) else $error("trip left output on");
	a_summary: assert property (@(posedge clk) disable iff (srst)
		##1 group_summary == |($past(ev_nxt) & $past(event_enable)))
		else $error("summary mismatch");
	a_seq_err: assert property (@(posedge clk) disable iff (srst)
		seq_empty && !on_blocked && !seq_lim_bad |=> seq_abort && error_code == ERR_SEQ_EMPTY)
		else $error("empty sequence not aborted");
	a_query_err: assert property (@(posedge clk) disable iff (srst)
		cmd.talk_addr && !out_buf_nonempty |=> event_flags[EV_QUERY_ERR])
		else $error("query error lost");

endmodule : status_event_flag_manager

/* rtl/status_flags_pkg.sv */
/*
 * Package for the status and event flag manager: constants, flag indices, error codes
 * and the packed carriers shared by the ports.
 * Assumes a 40 MHz system clock and a synchronous active-high reset.
 */
package status_flags_pkg;

	// Clock and delay timing
	localparam int unsigned CLK_HZ = 40000000;
	localparam int unsigned MS_PER_S = 1000;
	localparam int unsigned TICK_MS = 1;
	localparam int unsigned TICK_CYCLES = CLK_HZ / MS_PER_S * TICK_MS;
	localparam int unsigned DELAY_MIN_MS = 1;
	localparam int unsigned DELAY_MAX_MS = 9999;
	localparam int unsigned OTP_OFF_S = 5;
	localparam int unsigned OTP_OFF_MS = OTP_OFF_S * MS_PER_S;
	localparam int unsigned HOST_BUF_CHARS = 255;
	localparam int unsigned MACRO_MAX_CHARS = 80;

	// Bit positions named by the flag rules
	localparam int unsigned GRP_B_LIMIT_BIT = 1;
	localparam int unsigned STD_EXEC_BIT = 4;

	// Error codes shown on the display
	localparam logic [7:0] ERR_SEQ_LIMIT = 8'h15;
	localparam logic [7:0] ERR_SEQ_EMPTY = 8'h16;
	localparam logic [7:0] ERR_OUT_BLOCKED = 8'h19;
	localparam logic [7:0] ERR_NONE = 8'h00;

	// Event vector indices
	localparam int unsigned EV_CUR_REG = 0;
	localparam int unsigned EV_VOLT_REG = 1;
	localparam int unsigned EV_CMD_ERR = 2;
	localparam int unsigned EV_MACRO_ERR = 3;
	localparam int unsigned EV_RUN_FAULT = 4;
	localparam int unsigned EV_LIMIT_ERR = 5;
	localparam int unsigned EV_OC_TRIP = 6;
	localparam int unsigned EV_PWR_LIM = 7;
	localparam int unsigned EV_OP_DONE = 8;
	localparam int unsigned EV_OT_ALARM = 9;
	localparam int unsigned EV_OT_CLEAR = 10;
	localparam int unsigned EV_OUT_BLOCK = 11;
	localparam int unsigned EV_OV_TRIP = 12;
	localparam int unsigned EV_PWR_CYCLE = 13;
	localparam int unsigned EV_QUERY_ERR = 14;
	localparam int unsigned EV_SEQ_DONE = 15;
	localparam int unsigned EV_SEQ_ERR = 16;
	localparam int unsigned EV_TRIG = 17;
	localparam int unsigned EV_N = 18;
	localparam logic [EV_N-1:0] EV_RESET = 18'h02000;

	// Commands and reports from the parser, one-cycle pulses
	typedef struct packed {
		logic cmd_unknown;
		logic cmd_syntax;
		logic cmd_range;
		logic [7:0] macro_len;
		logic macro_define;
		logic macro_has_trig;
		logic param_fault;
		logic state_conflict;
		logic volt_set_wr;
		logic volt_lim_wr;
		logic cur_set_wr;
		logic cur_lim_wr;
		logic output_on_cmd;
		logic output_off_cmd;
		logic opc_cmd;
		logic talk_addr;
		logic seq_go;
		logic clear_status;
		logic delay_cmd;
		logic [13:0] delay_ms;
	} cmd_t;

	// Set-point and limit values offered with writes
	typedef struct packed {
		logic [15:0] volt_new;
		logic [15:0] cur_new;
		logic [15:0] seq_volt;
		logic [15:0] seq_cur;
		logic seq_has_entries;
	} values_t;

	// Live analog-side conditions from pins
	typedef struct packed {
		logic cur_reg;
		logic volt_reg;
		logic pwr_lim;
		logic oc_trip;
		logic ov_trip;
		logic over_temp;
		logic trig_off;
		logic trig_pulse;
		logic seq_active;
	} cond_t;

	// Power-on behaviour selections
	typedef enum logic [1:0] {
		PON_STANDBY = 2'b00,
		PON_RESET = 2'b01,
		PON_RECALL = 2'b11
	} pon_mode_t;

	// Delay sequencer
	typedef enum logic [1:0] {
		DLY_IDLE = 2'b00,
		DLY_RUN = 2'b01,
		DLY_LAST = 2'b11
	} dly_state_t;

endpackage : status_flags_pkg

/* dv/host_model.sv */
/*
 * Host-side model that feeds one-cycle parser command pulses to the flag manager.
 * Assumes send is called just after a rising edge of clk.
 */
module host_model (
	input wire logic clk,
	input wire logic parser_hold,
	output status_flags_pkg::cmd_t cmd
);
	timeunit 1ns;
	timeprecision 100ps;
	import status_flags_pkg::*;
	int str_chars = 0;

	// Idle between commands, so no stray pulse is seen
	initial cmd = '0;

	// One command of len characters as a single-cycle pulse
	task automatic send(input cmd_t c, input int len);
		int n;
		n = 0;
		if (str_chars + len > HOST_BUF_CHARS) str_chars = 0;
		str_chars += len;
		while (parser_hold === 1'b1 && n < 50000) begin
			n++;
			@(posedge clk);
			#2;
		end
		cmd = c;
		@(posedge clk);
		#2;
		cmd = '0;
	endtask : send
endmodule : host_model

/* dv/testbench.sv */
/*
 * Self-checking bench for the status and event flag manager.
 * Assumes host_model drives the command pulses; tick counts are shortened.
 */
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import status_flags_pkg::*;
	localparam int unsigned TICK = 4;
	logic clk = 1'b0;
	logic srst = 1'b1;
	cmd_t cmd;
	cmd_t c;
	values_t vals = '0;
	cond_t cond_pin = '0;
	pon_mode_t pon_mode = PON_STANDBY;
	logic out_buf_nonempty = 1'b0;
	logic event_read = 1'b0;
	logic [EV_N-1:0] event_enable = '0;
	logic [EV_N-1:0] event_flags;
	logic [EV_N-1:0] cond_flags;
	logic group_summary, message_available_flag, sequence_running_flag, std_exec_err;
	logic output_enable, parser_hold, seq_abort;
	logic [7:0] error_code;
	logic [15:0] voltage_setpoint, voltage_limit, current_setpoint, current_limit;
	int err_count = 0;
	int checks_done = 0;
	int cycles = 0;
	int n;
	int sh[7] = '{8, 7, 6, 5, 4, 3, 1};
	int evi[7] = '{EV_CUR_REG, EV_VOLT_REG, EV_PWR_LIM, EV_OC_TRIP, EV_OV_TRIP,
		EV_OT_ALARM, EV_TRIG};
	logic [13:0] dl[4] = '{14'h0001, 14'h0003, 14'h0000, 14'h2710};
	int dl_exp[4] = '{TICK, 3 * TICK, 0, 0};

	status_event_flag_manager #(.TICK_LEN(TICK), .OTP_DELAY_MS(3)) status_event_flag_manager_inst (
		.clk(clk), .srst(srst), .cmd(cmd), .vals(vals), .cond_pin(cond_pin),
		.pon_mode(pon_mode), .out_buf_nonempty(out_buf_nonempty), .event_read(event_read),
		.event_enable(event_enable), .event_flags(event_flags), .cond_flags(cond_flags),
		.group_summary(group_summary), .message_available_flag(message_available_flag),
		.sequence_running_flag(sequence_running_flag), .std_exec_err(std_exec_err),
		.output_enable(output_enable), .parser_hold(parser_hold), .error_code(error_code),
		.voltage_setpoint(voltage_setpoint), .voltage_limit(voltage_limit),
		.current_setpoint(current_setpoint), .current_limit(current_limit),
		.seq_abort(seq_abort)
	);

	host_model host_model_inst (.clk(clk), .parser_hold(parser_hold), .cmd(cmd));

	// Free-running 40 MHz clock
	always #12.5 clk = ~clk;

	// Hang guard: the whole sequence needs well under 2000 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			err_count++;
			print_verdict();
		end
	end

	function automatic logic [EV_N-1:0] ev(input int i);
		return 18'h1 << i;
	endfunction : ev

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#2;
	endtask : cyc

	task automatic chk(input string nm, input logic [EV_N-1:0] e, input logic [EV_N-1:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Send a command, compare the events left, then clear them with a read
	task automatic ev_case(input cmd_t k, input logic [EV_N-1:0] e);
		host_model_inst.send(k, 8);
		cyc(1);
		chk("events", e, event_flags);
		event_read = 1'b1;
		cyc(1);
		event_read = 1'b0;
	endtask : ev_case

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : print_verdict

	// Main sequence; the first block also checks reset values
	initial begin
		cyc(4);
		srst = 1'b0;
		chk("events", EV_RESET, event_flags);
		chk("vlim", 18'h0FFFF, 18'(voltage_limit));
		chk("hold", 18'h0, 18'(parser_hold));
		chk("summary", 18'h0, 18'(group_summary));
		ev_case('0, EV_RESET);
		chk("events", 18'h0, event_flags);
		c = '0;
		c.volt_lim_wr = 1'b1;
		vals.volt_new = 16'h0064;
		ev_case(c, 18'h0);
		vals.volt_new = 16'h0020;
		c = '0;
		c.volt_set_wr = 1'b1;
		ev_case(c, 18'h0);
		c = '0;
		c.volt_lim_wr = 1'b1;
		vals.volt_new = 16'h001F;
		ev_case(c, ev(EV_LIMIT_ERR));
		chk("vlim", 18'h00064, 18'(voltage_limit));
		c = '0;
		c.volt_set_wr = 1'b1;
		vals.volt_new = 16'h0065;
		host_model_inst.send(c, 8);
		cyc(1);
		chk("exec", 18'h1, 18'(std_exec_err));
		ev_case('0, ev(EV_LIMIT_ERR));
		chk("vset", 18'h00020, 18'(voltage_setpoint));
		c = '0;
		c.cur_lim_wr = 1'b1;
		vals.cur_new = 16'h0030;
		ev_case(c, 18'h0);
		c = '0;
		c.cur_set_wr = 1'b1;
		vals.cur_new = 16'h0031;
		ev_case(c, ev(EV_LIMIT_ERR));
		chk("current_limit", 18'h00030, 18'(current_limit));
		chk("iset", 18'h0, 18'(current_setpoint));
		vals.cur_new = 16'h0010;
		ev_case(c, 18'h0);
		chk("iset", 18'h00010, 18'(current_setpoint));
		c = '0;
		c.cmd_unknown = 1'b1;
		ev_case(c, ev(EV_CMD_ERR));
		c = '0;
		c.cmd_syntax = 1'b1;
		ev_case(c, ev(EV_CMD_ERR));
		c = '0;
		c.cmd_range = 1'b1;
		ev_case(c, ev(EV_CMD_ERR));
		c = '0;
		c.param_fault = 1'b1;
		ev_case(c, ev(EV_RUN_FAULT));
		c = '0;
		c.state_conflict = 1'b1;
		ev_case(c, ev(EV_RUN_FAULT));
		c = '0;
		c.macro_define = 1'b1;
		c.macro_len = 8'h50;
		ev_case(c, 18'h0);
		c.macro_len = 8'h51;
		ev_case(c, ev(EV_MACRO_ERR));
		c.macro_len = 8'h10;
		c.macro_has_trig = 1'b1;
		ev_case(c, ev(EV_MACRO_ERR));
		// Delay lengths at the low end of the range, 3 ms, and just outside both ends
		foreach (dl[i]) begin
			c = '0;
			c.delay_cmd = 1'b1;
			c.delay_ms = dl[i];
			host_model_inst.send(c, 8);
			n = 0;
			while (parser_hold === 1'b1 && n < 50000) begin
				n++;
				cyc(1);
			end
			chk("hold_cycles", 18'(dl_exp[i]), 18'(n));
			cyc(1);
		end
		c.delay_ms = 14'h0002;
		host_model_inst.send(c, 8);
		chk("hold", 18'h1, 18'(parser_hold));
		c = '0;
		c.opc_cmd = 1'b1;
		ev_case(c, ev(EV_OP_DONE));
		event_enable = '1;
		// Each live condition: sticky event on its rise, output reaction
		for (int i = 0; i < 7; i++) begin
			c = '0;
			c.output_on_cmd = 1'b1;
			host_model_inst.send(c, 8);
			cond_pin = cond_t'(9'h001 << sh[i]);
			cyc(20);
			chk("events", ev(evi[i]), event_flags);
			chk("summary", 18'h1, 18'(group_summary));
			if (i < 2) chk("cond", ev(evi[i]), cond_flags);
			cond_pin = '0;
			cyc(4);
			chk("out_on", 18'(!(i inside {[3:5]})), 18'(output_enable));
			chk("events", (i == 5) ? ev(EV_OT_CLEAR) | ev(EV_OT_ALARM) : ev(evi[i]),
				event_flags);
			c = '0;
			c.clear_status = 1'b1;
			ev_case(c, 18'h0);
		end
		cond_pin = cond_t'(9'h004);
		cyc(4);
		c = '0;
		c.output_on_cmd = 1'b1;
		ev_case(c, ev(EV_OUT_BLOCK));
		chk("out_on", 18'h0, 18'(output_enable));
		chk("errcode", 18'h19, 18'(error_code));
		cond_pin = '0;
		cyc(4);
		ev_case(c, 18'h0);
		cond_pin = cond_t'(9'h008);
		cyc(20);
		ev_case('0, ev(EV_OT_ALARM));
		ev_case(c, ev(EV_OT_ALARM));
		chk("out_on", 18'h0, 18'(output_enable));
		pon_mode = PON_RECALL;
		cond_pin = '0;
		cyc(4);
		ev_case('0, ev(EV_OT_CLEAR));
		chk("out_on", 18'h1, 18'(output_enable));
		c = '0;
		c.seq_go = 1'b1;
		vals.seq_volt = 16'h0065;
		vals.seq_has_entries = 1'b1;
		ev_case(c, ev(EV_SEQ_ERR));
		chk("errcode", 18'h15, 18'(error_code));
		vals.seq_volt = 16'h0010;
		vals.seq_has_entries = 1'b0;
		host_model_inst.send(c, 8);
		chk("abort", 18'h1, 18'(seq_abort));
		ev_case('0, ev(EV_SEQ_ERR));
		chk("errcode", 18'h16, 18'(error_code));
		cond_pin = cond_t'(9'h001);
		cyc(4);
		chk("seq_run", 18'h1, 18'(sequence_running_flag));
		cond_pin = '0;
		cyc(4);
		ev_case('0, ev(EV_SEQ_DONE));
		c = '0;
		c.talk_addr = 1'b1;
		ev_case(c, ev(EV_QUERY_ERR));
		out_buf_nonempty = 1'b1;
		cyc(2);
		chk("mav", 18'h1, 18'(message_available_flag));
		ev_case(c, 18'h0);
		print_verdict();
	end
endmodule : testbench
